/* rtl/fifo_ctl_cfg.svh */
// constants for the fifo reset, configuration and mailbox control block
`ifndef FIFO_CTL_CFG_SVH
`define FIFO_CTL_CFG_SVH
`define FC_DATA_W      36
`define FC_ADDR_W      10
`define FC_CFG_W       8
`define FC_CFG_BITS    32
`define FC_CFG_DEFAULT 32'h0000_0000
`define FC_PTR_ZERO    10'h000
`define FC_BUF_DEPTH   2
`define FC_SYNC_IDLE   7'h70 // resets and enable high, the rest low
`endif

/* rtl/fifo_ctl_pkg.sv */
// types shared by the fifo reset, configuration and mailbox control block
package fifo_ctl_pkg;
    typedef enum logic [1:0] {
        RST_NONE,
        RST_PARTIAL,
        RST_MASTER
    } reset_kind_t;
endpackage : fifo_ctl_pkg

/* rtl/fifo_ctl.sv */
// fifo core with resets, serial config, mark/retransmit and mailbox
// Function
// - master reset zeroes read and write pointers and output register
// - master reset restores configuration defaults and clears flags
// - partial reset zeroes read and write pointers and output register
// - partial reset keeps configuration but clears flags
// - serial clock rising edge with enable shifts serial bit in
// - serial clock edges are ignored unless serial enable is active
// - mark records the current read pointer as retransmit position
// - retransmit reloads read pointer with recorded position
// - mailbox select routes reads and writes to mailbox register
// - after retransmit reads replay data until read meets write
// - load select low moves low byte to or from configuration
`timescale 1ns/1ns
`include "fifo_ctl_cfg.svh"
module fifo_ctl #(
    parameter int DATA_W = `FC_DATA_W,
    parameter int ADDR_W = `FC_ADDR_W
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              master_reset_n_i,
    input  wire logic              partial_reset_n_i,
    input  wire logic              serial_clk_i,
    input  wire logic              serial_data_i,
    input  wire logic              serial_cfg_enable_n_i,
    input  wire logic              mark_i,
    input  wire logic              retransmit_request_i,
    input  wire logic              mailbox_select_i,
    input  wire logic              config_load_select_i,
    input  wire logic              wr_valid_i,
    output logic                   wr_ready_o,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              rd_ready_i,
    output logic                   rd_valid_o,
    output logic      [DATA_W-1:0] rd_data_o,
    output logic                   empty_o,
    output logic                   full_o,
    output logic [`FC_CFG_BITS-1:0] config_o
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int CW    = `FC_CFG_W;

    // two-flop synchronisers for all pins from outside the clock domain
    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    // reset to idle pin levels so no reset, enable or edge appears
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_reg <= `FC_SYNC_IDLE;
            sync2_reg <= `FC_SYNC_IDLE;
        end else begin
            sync1_reg <= {master_reset_n_i, partial_reset_n_i,
                          serial_cfg_enable_n_i, serial_clk_i,
                          serial_data_i, mark_i, retransmit_request_i};
            sync2_reg <= sync1_reg;
        end
    end
    // active-high views of the synchronised pins
    logic master_reset;
    logic partial_reset;
    logic sen;
    logic sclk_s;
    logic sdat_s;
    logic mark_s;
    logic rt_s;
    assign master_reset    = ~sync2_reg[6];
    assign partial_reset    = ~sync2_reg[5];
    assign sen    = ~sync2_reg[4];
    assign sclk_s = sync2_reg[3];
    assign sdat_s = sync2_reg[2];
    assign mark_s = sync2_reg[1];
    assign rt_s   = sync2_reg[0];

    // decode which reset is active, master first
    fifo_ctl_pkg::reset_kind_t rst_kind;
    always_comb begin
        if (master_reset) begin
            rst_kind = fifo_ctl_pkg::RST_MASTER;
        end else if (partial_reset) begin
            rst_kind = fifo_ctl_pkg::RST_PARTIAL;
        end else begin
            rst_kind = fifo_ctl_pkg::RST_NONE;
        end
    end
    // either reset blocks writes and clears the read path
    logic any_rst;
    assign any_rst = (rst_kind != fifo_ctl_pkg::RST_NONE);

    // serial clock edge detect on the synchronised level
    logic sclk_d_reg;
    logic rt_d_reg;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_d_reg <= 1'b0;
            rt_d_reg   <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            rt_d_reg   <= rt_s;
        end
    end
    // one-cycle strobes on rising serial clock and retransmit
    logic sclk_rise;
    logic rt_rise;
    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign rt_rise   = rt_s & ~rt_d_reg;

    // fifo-side handshake wires from the buffer and storage
    logic buf_in_ready;
    logic core_rd;
    logic cfg_wr;
    logic mbx_wr;
    logic mbx_rd;
    logic core_wr;

    // configuration register: serial shift or parallel low-byte load
    logic [`FC_CFG_BITS-1:0] config_reg;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            config_reg <= `FC_CFG_DEFAULT;
        end else if (rst_kind == fifo_ctl_pkg::RST_MASTER) begin
            config_reg <= `FC_CFG_DEFAULT;
        end else if (rst_kind == fifo_ctl_pkg::RST_PARTIAL) begin
            config_reg <= config_reg;
        end else if (sen && sclk_rise) begin
            config_reg <= {config_reg[`FC_CFG_BITS-2:0], sdat_s};
        end else if (cfg_wr) begin
            config_reg <= {config_reg[`FC_CFG_BITS-CW-1:0],
                           wr_data_i[CW-1:0]};
        end
    end // serial edges without enable fall through
    assign config_o = config_reg;

    // write routing by mailbox and load select
    assign mbx_wr  = wr_valid_i && wr_ready_o && mailbox_select_i;
    assign cfg_wr  = wr_valid_i && wr_ready_o && !mailbox_select_i
                     && !config_load_select_i;
    assign core_wr = wr_valid_i && wr_ready_o && !mailbox_select_i
                     && config_load_select_i;

    // storage array and pointers
    logic [DATA_W-1:0] mem [DEPTH];
    logic [ADDR_W:0]   wptr_reg;
    logic [ADDR_W:0]   rptr_reg;
    logic [ADDR_W:0]   mark_ptr_reg;
    logic              mark_valid_reg;
    always_ff @(posedge ref_clk_i) begin
        if (core_wr && !any_rst) begin
            mem[wptr_reg[ADDR_W-1:0]] <= wr_data_i;
        end
    end
    // core flags: the extra pointer bit tells full from empty
    assign empty_o = (rptr_reg == wptr_reg);
    assign full_o  = (rptr_reg[ADDR_W-1:0] == wptr_reg[ADDR_W-1:0])
                     && (rptr_reg[ADDR_W] != wptr_reg[ADDR_W]);
    // writes are refused only during a reset or into a full core
    assign wr_ready_o = !any_rst && (mailbox_select_i
                        || !config_load_select_i || !full_o);

    // retransmit reload; it also drops words prefetched past the mark
    logic rt_load;
    logic buf_flush;
    assign rt_load   = rt_rise && mark_valid_reg;
    assign buf_flush = any_rst || (rt_load && config_load_select_i
                                   && !mailbox_select_i);

    // write pointer
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wptr_reg <= '0;
        end else if (any_rst) begin
            wptr_reg <= '0;
        end else if (core_wr) begin
            wptr_reg <= wptr_reg + 1'b1;
        end
    end

    // read pointer with retransmit reload
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rptr_reg <= '0;
        end else if (any_rst) begin
            rptr_reg <= '0;
        end else if (rt_load) begin
            rptr_reg <= mark_ptr_reg;
        end else if (core_rd) begin
            rptr_reg <= rptr_reg + 1'b1;
        end
    end

    // mark position capture
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mark_ptr_reg   <= '0;
            mark_valid_reg <= 1'b0;
        end else if (any_rst) begin
            mark_ptr_reg   <= '0;
            mark_valid_reg <= 1'b0;
        end else if (mark_s) begin
            mark_ptr_reg   <= rptr_reg;
            mark_valid_reg <= 1'b1;
        end
    end

    // mailbox register, flow-through path
    logic [DATA_W-1:0] mbx_reg;
    logic              mbx_full_reg;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mbx_reg      <= '0;
            mbx_full_reg <= 1'b0;
        end else if (any_rst) begin
            mbx_full_reg <= 1'b0;
        end else if (mbx_wr) begin
            mbx_reg      <= wr_data_i;
            mbx_full_reg <= 1'b1;
        end else if (mbx_rd) begin
            mbx_full_reg <= 1'b0;
        end
    end

    // read source selection feeding the output buffer
    logic              src_valid;
    logic [DATA_W-1:0] src_data;
    always_comb begin
        src_valid = 1'b0;
        src_data  = '0;
        if (mailbox_select_i) begin
            src_valid = mbx_full_reg;
            src_data  = mbx_reg;
        end else if (!config_load_select_i) begin
            src_valid = 1'b1;
            src_data  = {{(DATA_W-CW){1'b0}},
                         config_reg[CW-1:0]};
        end else begin
            src_valid = !empty_o;
            src_data  = mem[rptr_reg[ADDR_W-1:0]];
        end
        if (any_rst || rt_rise) begin
            src_valid = 1'b0;
        end
    end
    // a word moves into the buffer when offered and room exists
    logic take;
    assign take    = src_valid && buf_in_ready;
    assign mbx_rd  = take && mailbox_select_i;
    assign core_rd = take && !mailbox_select_i && config_load_select_i;

    // two-entry output buffer; stall by the reader loses no word
    logic [DATA_W-1:0] buf_mem [`FC_BUF_DEPTH];
    logic              buf_wp_reg;
    logic              buf_rp_reg;
    logic [1:0]        buf_cnt_reg;
    logic              buf_pop;
    assign buf_in_ready = (buf_cnt_reg != 2'(`FC_BUF_DEPTH));
    // nothing is offered to the reader in the cycle of a flush
    assign rd_valid_o   = (buf_cnt_reg != 2'h0) && !buf_flush;
    assign buf_pop      = rd_valid_o && rd_ready_i;
    // buffer pointers and fill count
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_wp_reg  <= 1'b0;
            buf_rp_reg  <= 1'b0;
            buf_cnt_reg <= 2'h0;
        end else if (buf_flush) begin
            buf_wp_reg  <= 1'b0;
            buf_rp_reg  <= 1'b0;
            buf_cnt_reg <= 2'h0;
        end else begin
            if (take) begin
                buf_wp_reg <= ~buf_wp_reg;
            end
            if (buf_pop) begin
                buf_rp_reg <= ~buf_rp_reg;
            end
            buf_cnt_reg <= buf_cnt_reg + 2'(take) - 2'(buf_pop);
        end
    end
    // buffer storage, written at the write slot on every take
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else if (any_rst) begin
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else if (take) begin
            buf_mem[buf_wp_reg] <= src_data;
        end
    end

    // output register cleared by either reset
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_o <= '0;
        end else if (any_rst) begin
            rd_data_o <= '0;
        end else if (buf_pop) begin
            rd_data_o <= buf_mem[buf_rp_reg];
        end
    end
endmodule : fifo_ctl

/* dv/fifo_ctl_checker.sv */
// port checks for the fifo control block
`timescale 1ns/1ns
`include "fifo_ctl_cfg.svh"
module fifo_ctl_checker (
    input wire logic                    ref_clk_i,
    input wire logic                    rstn_i,
    input wire logic                    master_reset_n_i,
    input wire logic                    partial_reset_n_i,
    input wire logic                    serial_cfg_enable_n_i,
    input wire logic                    config_load_select_i,
    input wire logic                    mailbox_select_i,
    input wire logic                    wr_ready_o,
    input wire logic                    full_o,
    input wire logic [`FC_DATA_W-1:0]   rd_data_o,
    input wire logic [`FC_CFG_BITS-1:0] config_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    // resets clear the output register and refuse writes
    chk_master_clears: assert property (
        !master_reset_n_i [*5] |-> !wr_ready_o && rd_data_o == '0)
        else $error("master reset kept data");
    chk_master_defaults: assert property (
        !master_reset_n_i [*5] |-> config_o == `FC_CFG_DEFAULT && !full_o)
        else $error("master reset kept config");
    chk_partial_clears: assert property (
        !partial_reset_n_i [*5] |-> !wr_ready_o && rd_data_o == '0)
        else $error("partial reset kept data");
    chk_partial_flags: assert property (
        !partial_reset_n_i [*5] |-> !full_o)
        else $error("partial reset kept flag");
    // config holds while nothing may change it
    chk_partial_keeps_cfg: assert property (
        (master_reset_n_i && serial_cfg_enable_n_i && !partial_reset_n_i)
        [*6] |-> $stable(config_o))
        else $error("partial reset changed config");
    chk_serial_idle_cfg: assert property (
        (serial_cfg_enable_n_i && config_load_select_i && master_reset_n_i)
        [*6] |-> $stable(config_o))
        else $error("config changed without enable");
    chk_full_refused: assert property (
        full_o && config_load_select_i && !mailbox_select_i |-> !wr_ready_o)
        else $error("write taken while full");
    chk_master_wins: assert property (
        (!master_reset_n_i && !partial_reset_n_i) [*5]
        |-> config_o == `FC_CFG_DEFAULT)
        else $error("partial reset beat master");
    cov_full: cover property (full_o && config_load_select_i);
    cov_partial: cover property (!partial_reset_n_i [*6]);
    cov_master: cover property (!master_reset_n_i [*6]);
endmodule : fifo_ctl_checker

bind fifo_ctl fifo_ctl_checker u_fifo_ctl_checker (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .master_reset_n_i(master_reset_n_i),
    .partial_reset_n_i(partial_reset_n_i),
    .serial_cfg_enable_n_i(serial_cfg_enable_n_i),
    .config_load_select_i(config_load_select_i),
    .mailbox_select_i(mailbox_select_i), .wr_ready_o(wr_ready_o),
    .full_o(full_o), .rd_data_o(rd_data_o), .config_o(config_o));

/* dv/serial_host.sv */
// host model driving the serial configuration pins
`timescale 1ns/1ns
module serial_host (
    output logic sclk_o,
    output logic sdata_o,
    output logic sen_n_o
);
    // clock idles low between frames
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        sen_n_o = 1'b1;
    end
    // one byte msb first at 125 ns; en low sends edges unqualified
    task automatic shift(input logic [7:0] b, input logic en);
        // step off the caller's clock edge before touching the pins
        #1;
        sen_n_o = !en;
        for (int i = 7; i >= 0; i--) begin
            sdata_o = b[i];
            #62 sclk_o = 1'b1;
            #63 sclk_o = 1'b0;
        end
        #62 sen_n_o = 1'b1;
        sdata_o = ~sdata_o; // released line shows no stale bit
    endtask : shift
endmodule : serial_host

/* dv/fifo_ctl_tb_top.sv */
// self-checking bench for the fifo control block
`timescale 1ns/1ns
`include "fifo_ctl_cfg.svh"
module fifo_ctl_tb_top;
    logic ref_clk_i = 1'b0, rstn_i = 1'b0, m_n = 1'b1, p_n = 1'b1;
    logic mark = 1'b0, retx = 1'b0, mbox = 1'b0, load = 1'b1;
    logic wv = 1'b0, rr = 1'b0, sclk, sdat, sen_n, wrdy, rv, emp, full;
    logic [`FC_DATA_W-1:0]   wd = 36'h0, rdat;
    logic [`FC_CFG_BITS-1:0] cfg;
    int failures = 0, compares = 0, cycles = 0;
    // 100 MHz clock
    always #5 ref_clk_i = ~ref_clk_i;
    serial_host u_serial_host (.sclk_o(sclk), .sdata_o(sdat), .sen_n_o(sen_n));
    fifo_ctl #(.ADDR_W(4)) u_fifo_ctl (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .master_reset_n_i(m_n),
        .partial_reset_n_i(p_n), .serial_clk_i(sclk), .serial_data_i(sdat),
        .serial_cfg_enable_n_i(sen_n), .mark_i(mark),
        .retransmit_request_i(retx), .mailbox_select_i(mbox),
        .config_load_select_i(load), .wr_valid_i(wv), .wr_ready_o(wrdy),
        .wr_data_i(wd), .rd_ready_i(rr), .rd_valid_o(rv), .rd_data_o(rdat),
        .empty_o(emp), .full_o(full), .config_o(cfg));
    task automatic stop_test;
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick
    // one write, held until taken
    task automatic wr(input logic [35:0] d);
        tick(1);
        wv <= 1'b1;
        wd <= d;
        do @(posedge ref_clk_i); while (wrdy !== 1'b1);
        wv <= 1'b0;
    endtask : wr
    // one pop, then check the output register
    task automatic rd(input logic [35:0] e);
        tick(1);
        rr <= 1'b1;
        do @(posedge ref_clk_i); while (rv !== 1'b1);
        rr <= 1'b0;
        tick(1);
        cmp(rdat, e);
    endtask : rd
    task automatic pins(input logic m, input logic p);
        tick(1);
        m_n <= m;
        p_n <= p;
        tick(6);
    endtask : pins
    task automatic t_cfg;
        cmp(36'(cfg), 36'(`FC_CFG_DEFAULT));
        tick(1);
        load <= 1'b0;
        wr(36'hF_FFFF_FFA5);
        wr(36'h0_0000_003C);
        // two default bytes were buffered before the writes landed
        rd(36'h0);
        rd(36'h0);
        rd(36'h0_0000_003C);
        tick(1);
        load <= 1'b1;
        // flush the streamed config bytes; settings must survive
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
        cmp(36'(cfg), 36'h0_0000_A53C);
    endtask : t_cfg
    task automatic t_serial;
        u_serial_host.shift(8'h5A, 1'b1);
        tick(6);
        cmp(36'(cfg), 36'h0_00A5_3C5A);
        u_serial_host.shift(8'hC3, 1'b0);
        tick(6);
        cmp(36'(cfg), 36'h0_00A5_3C5A);
    endtask : t_serial
    task automatic t_partial;
        wr(36'h1);
        wr(36'h2);
        rd(36'h1);
        pins(1'b1, 1'b0);
        cmp(36'(cfg), 36'h0_00A5_3C5A);
        cmp(rdat, 36'h0);
        pins(1'b1, 1'b1);
        cmp(36'(emp), 36'h1);
    endtask : t_partial
    // fill until refused with reader stalled, then drain in order
    task automatic t_fill;
        int n;
        n = 0;
        tick(1);
        wv <= 1'b1;
        wd <= 36'h0;
        forever begin
            tick(1);
            if (wrdy !== 1'b1) break;
            n++;
            wd <= 36'(n);
        end
        wv <= 1'b0;
        cmp(36'(full), 36'h1);
        for (int i = 0; i < n; i++) rd(36'(i));
    endtask : t_fill
    task automatic t_retx;
        tick(1);
        mark <= 1'b1;
        tick(1);
        mark <= 1'b0;
        for (int i = 1; i < 4; i++) wr(36'hA_0000_0000 + 36'(i));
        for (int i = 1; i < 4; i++) rd(36'hA_0000_0000 + 36'(i));
        retx <= 1'b1;
        tick(2);
        retx <= 1'b0;
        for (int i = 1; i < 4; i++) rd(36'hA_0000_0000 + 36'(i));
        tick(4);
        cmp(36'(rv), 36'h0);
    endtask : t_retx
    task automatic t_mbox;
        tick(1);
        mbox <= 1'b1;
        wr(36'h9_8765_4321);
        rd(36'h9_8765_4321);
        mbox <= 1'b0;
        tick(2);
        cmp(36'(emp), 36'h1);
    endtask : t_mbox
    task automatic t_master;
        pins(1'b0, 1'b0);
        cmp(36'(cfg), 36'(`FC_CFG_DEFAULT));
        cmp(rdat, 36'h0);
        pins(1'b1, 1'b1);
        cmp(36'(emp), 36'h1);
    endtask : t_master
    // cut a hang short
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            stop_test;
        end
    end
    // main sequence
    initial begin
        tick(20);
        rstn_i <= 1'b1;
        tick(5);
        t_cfg;
        t_serial;
        t_partial;
        t_fill;
        t_retx;
        t_mbox;
        t_master;
        stop_test;
    end
endmodule : fifo_ctl_tb_top
